/* File: hdl/power_monitor_register_map.sv */
// register map and global setup of the power monitor behind its serial port
`timescale 1ns/1ps
module power_monitor_register_map
	import pwrmon_pkg::*;
#(
	parameter int CONV_DELAY_STEP_CYCLES = CONV_DELAY_STEP_CYC,
	parameter logic [15:0] MAKER_CODE = 16'h1234, // arbitrary value
	parameter logic [15:0] PART_CODE = 16'h5678 // arbitrary value
) (
	// system clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// serial port, its clock is the link domain
	input wire logic spi_clk_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_mosi_in,
	output logic spi_miso_out,
	output logic spi_miso_oe_out,
	// measurement results from the converter logic
	input wire meas_t meas_in,
	// configuration towards the converter logic
	output cfg_t cfg_out,
	output logic conv_start_out
);
	// link domain, falling edge: frame control, cleared while chip select is high
	typedef struct packed {
		logic [5:0] bit_cnt;
		logic rd_req;
		logic wr_req;
	} link_ctl_t;

	// link domain, falling edge: frame contents, only read under a request level
	typedef struct packed {
		logic [5:0] addr;
		logic dir_read;
		logic [15:0] rx;
	} link_data_t;

	// system domain state
	typedef struct packed {
		cfg_t cfg;
		logic [23:0] rd_word;
		logic rd_ack;
		logic wr_seen;
		logic soft_rst;
		logic conv_restart;
	} map_state_t;

	link_ctl_t ctl_r;
	link_ctl_t ctl_nxt;
	link_data_t dat_r;
	link_data_t dat_nxt;
	logic [23:0] tx_r;
	logic [23:0] tx_nxt;
	logic ack_s;
	map_state_t map_r;
	map_state_t map_nxt;
	logic [1:0] req_s;
	logic rd_req_s;
	logic wr_req_s;

	function automatic logic is_thr(input logic [5:0] a);
		is_thr = (a >= ADDR_THR_FIRST) && (a <= ADDR_THR_LAST);
	endfunction

	function automatic logic [15:0] global_word(input cfg_t c);
		logic [15:0] w;
		w = 16'h0000;
		w[GS_DELAY_MSB:GS_DELAY_LSB] = c.conversion_start_delay;
		w[GS_RANGE_BIT] = c.shunt_range_select;
		global_word = w;
	endfunction

	// left aligned in 24 bits so the first data bit is always bit 23
	function automatic logic [23:0] read_word(input logic [5:0] a, input cfg_t c,
		input meas_t m);
		logic [15:0] w;
		logic [2:0] idx;
		w = 16'h0000;
		idx = 3'(a - ADDR_THR_FIRST);
		if (is_thr(a))
			w = c.thresholds[idx];
		else
		begin
			case (a)
				ADDR_GLOBAL: w = global_word(c);
				ADDR_CONVERTER: w = c.converter_setup;
				ADDR_SHUNT_SCALE: w = c.shunt_scale_constant & SHUNT_SCALE_MASK;
				ADDR_SHUNT_V: w = m.shunt_voltage_result;
				ADDR_BUS_V: w = m.bus_voltage_result;
				ADDR_TEMP: w = m.die_temperature_result;
				ADDR_CURRENT: w = m.current_result;
				ADDR_DIAG: w = c.diagnostic_flag_register;
				ADDR_MAKER: w = MAKER_CODE;
				ADDR_PART: w = PART_CODE;
				default: w = 16'h0000;
			endcase
		end
		if (a == ADDR_POWER)
			read_word = m.power_result;
		else
			read_word = {w, 8'h00};
	endfunction

	// falling edge: command and write data in
	always_comb
	begin
		ctl_nxt = ctl_r;
		dat_nxt = dat_r;
		if (ctl_r.bit_cnt != CNT_MAX)
			ctl_nxt.bit_cnt = ctl_r.bit_cnt + 6'h01;
		if (ctl_r.bit_cnt < ADDR_BITS)
			dat_nxt.addr = {dat_r.addr[4:0], spi_mosi_in};
		if (ctl_r.bit_cnt == ADDR_BITS - 6'h01)
			ctl_nxt.rd_req = 1'b1;
		if (ctl_r.bit_cnt == DIR_BIT_POS)
			dat_nxt.dir_read = spi_mosi_in;
		if ((ctl_r.bit_cnt >= CMD_BITS) && (ctl_r.bit_cnt < WRITE_END))
			dat_nxt.rx = {dat_r.rx[14:0], spi_mosi_in};
		if ((ctl_r.bit_cnt == WRITE_END - 6'h01) && !dat_r.dir_read)
			ctl_nxt.wr_req = 1'b1;
	end

	// chip select high clears the frame at once, without a link clock edge
	always_ff @(negedge spi_clk_in or posedge spi_cs_n_in)
	begin
		if (spi_cs_n_in)
			ctl_r <= '0;
		else
			ctl_r <= ctl_nxt;
	end

	// contents outlive the frame so a late write still finds its data
	always_ff @(negedge spi_clk_in)
	begin
		dat_r <= dat_nxt;
	end

	sync2 #(
		.WIDTH(1)
	) ack_sync (
		.clk_in(spi_clk_in),
		.clr_in(spi_cs_n_in),
		.d_in(map_r.rd_ack),
		.q_out(ack_s)
	);

	// rising edge: eight low bits, then the fetched word MSB first
	always_comb
	begin
		tx_nxt = tx_r;
		if (ctl_r.bit_cnt == CMD_BITS)
			tx_nxt = ack_s ? map_r.rd_word : 24'h000000;
		else if (ctl_r.bit_cnt > CMD_BITS)
			tx_nxt = {tx_r[22:0], 1'b0};
	end

	always_ff @(posedge spi_clk_in or posedge spi_cs_n_in)
	begin
		if (spi_cs_n_in)
			tx_r <= 24'h000000;
		else
			tx_r <= tx_nxt;
	end

	assign spi_miso_out = tx_r[23];
	assign spi_miso_oe_out = !spi_cs_n_in;

	// request levels into the system domain
	sync2 #(
		.WIDTH(2)
	) req_sync (
		.clk_in(mclk_in),
		.clr_in(1'b0),
		.d_in({ctl_r.wr_req, ctl_r.rd_req}),
		.q_out(req_s)
	);

	assign rd_req_s = req_s[0];
	assign wr_req_s = req_s[1];

	always_comb
	begin
		map_nxt = map_r;
		map_nxt.soft_rst = 1'b0;
		map_nxt.conv_restart = 1'b0;
		map_nxt.wr_seen = wr_req_s;
		// fetch on the request, also for writes so the old value shifts out
		if (rd_req_s && !map_r.rd_ack)
		begin
			map_nxt.rd_word = read_word(dat_r.addr, map_r.cfg, meas_in);
			map_nxt.rd_ack = 1'b1;
		end
		else if (!rd_req_s)
			map_nxt.rd_ack = 1'b0;
		if (wr_req_s && !map_r.wr_seen)
		begin
			if (is_thr(dat_r.addr))
				map_nxt.cfg.thresholds[3'(dat_r.addr - ADDR_THR_FIRST)] = dat_r.rx;
			else
			begin
				case (dat_r.addr)
					ADDR_GLOBAL:
					begin
						map_nxt.cfg.conversion_start_delay =
							dat_r.rx[GS_DELAY_MSB:GS_DELAY_LSB];
						map_nxt.cfg.shunt_range_select = dat_r.rx[GS_RANGE_BIT];
						map_nxt.soft_rst = dat_r.rx[GS_RESET_BIT];
					end
					ADDR_CONVERTER:
					begin
						map_nxt.cfg.converter_setup = dat_r.rx;
						map_nxt.conv_restart = 1'b1;
					end
					ADDR_SHUNT_SCALE:
						map_nxt.cfg.shunt_scale_constant = dat_r.rx & SHUNT_SCALE_MASK;
					ADDR_DIAG:
						map_nxt.cfg.diagnostic_flag_register = dat_r.rx;
					// results, codes and reserved places ignore writes
					default:
						map_nxt.cfg = map_r.cfg;
				endcase
			end
		end
		// handshake levels survive a soft reset, else the write would repeat
		if (map_r.soft_rst)
		begin
			map_nxt.cfg = CFG_RESET;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			map_r <= '0;
			map_r.cfg <= CFG_RESET;
		end
		else
			map_r <= map_nxt;
	end

	assign cfg_out = map_r.cfg;

	conv_delay_timer #(
		.STEP_CYCLES(CONV_DELAY_STEP_CYCLES),
		.UNIT_W(8)
	) delay_timer (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.restart_in(map_r.soft_rst || map_r.conv_restart),
		.delay_in(map_r.cfg.conversion_start_delay),
		.conv_start_out(conv_start_out)
	);
endmodule

/* File: pkg/pwrmon_pkg.sv */
// constants, field layouts and carrier types of the power monitor register map
package pwrmon_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int POWER_W = 24;
	localparam int THR_COUNT = 6;

	localparam logic [5:0] ADDR_GLOBAL = 6'h00;
	localparam logic [5:0] ADDR_CONVERTER = 6'h01;
	localparam logic [5:0] ADDR_SHUNT_SCALE = 6'h02;
	localparam logic [5:0] ADDR_SHUNT_V = 6'h04;
	localparam logic [5:0] ADDR_BUS_V = 6'h05;
	localparam logic [5:0] ADDR_TEMP = 6'h06;
	localparam logic [5:0] ADDR_CURRENT = 6'h07;
	localparam logic [5:0] ADDR_POWER = 6'h08;
	localparam logic [5:0] ADDR_DIAG = 6'h0B;
	localparam logic [5:0] ADDR_THR_FIRST = 6'h0C;
	localparam logic [5:0] ADDR_THR_LAST = 6'h11;
	localparam logic [5:0] ADDR_MAKER = 6'h3E;
	localparam logic [5:0] ADDR_PART = 6'h3F;

	localparam int GS_RESET_BIT = 15;
	localparam int GS_DELAY_MSB = 13;
	localparam int GS_DELAY_LSB = 6;
	localparam int GS_RANGE_BIT = 4;

	localparam logic [15:0] GLOBAL_RESET = 16'h0000;
	localparam logic [15:0] CONVERTER_RESET = 16'hFB68;
	localparam logic [15:0] SHUNT_SCALE_RESET = 16'h1000;
	localparam logic [15:0] SHUNT_SCALE_MASK = 16'h7FFF;
	localparam logic [15:0] DIAG_RESET = 16'h0000;
	// index 0 is the shunt over threshold, index 5 the power over threshold
	localparam logic [THR_COUNT-1:0][15:0] THR_RESET =
		{16'h7FFF, 16'hFFFF, 16'h0000, 16'h7FFF, 16'h0000, 16'h7FFF};

	localparam logic [5:0] ADDR_BITS = 6'h06;
	localparam logic [5:0] DIR_BIT_POS = 6'h07;
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] WRITE_END = 6'h18;
	localparam logic [5:0] CNT_MAX = 6'h3F;

	localparam int CONV_DELAY_STEP_MS = 2;
	localparam longint MCLK_FREQ_HZ = 200_000_000;
	localparam int CONV_DELAY_STEP_CYC =
		int'((longint'(CONV_DELAY_STEP_MS) * MCLK_FREQ_HZ) / 64'd1000);

	typedef struct packed {
		logic [15:0] shunt_voltage_result;
		logic [15:0] bus_voltage_result;
		logic [15:0] die_temperature_result;
		logic [15:0] current_result;
		logic [23:0] power_result;
	} meas_t;

	typedef struct packed {
		logic [7:0] conversion_start_delay;
		logic shunt_range_select;
		logic [15:0] converter_setup;
		logic [15:0] shunt_scale_constant;
		logic [15:0] diagnostic_flag_register;
		logic [THR_COUNT-1:0][15:0] thresholds;
	} cfg_t;

	localparam cfg_t CFG_RESET = '{
		conversion_start_delay: GLOBAL_RESET[GS_DELAY_MSB:GS_DELAY_LSB],
		shunt_range_select: GLOBAL_RESET[GS_RANGE_BIT],
		converter_setup: CONVERTER_RESET,
		shunt_scale_constant: SHUNT_SCALE_RESET,
		diagnostic_flag_register: DIAG_RESET,
		thresholds: THR_RESET
	};
endpackage

/* File: hdl/sync2.sv */
// two flip-flop level synchroniser with asynchronous clear
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	// clock and clear
	input wire logic clk_in,
	input wire logic clr_in,
	// levels
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk_in or posedge clr_in)
	begin
		if (clr_in)
		begin
			meta_r <= '0;
			q_out <= '0;
		end
		else
		begin
			meta_r <= d_in;
			q_out <= meta_r;
		end
	end
endmodule

/* File: hdl/conv_delay_timer.sv */
// initial conversion delay timer, counting steps of the system clock
`timescale 1ns/1ps
module conv_delay_timer
	import pwrmon_pkg::*;
#(
	parameter int STEP_CYCLES = CONV_DELAY_STEP_CYC,
	parameter int UNIT_W = 8
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// control
	input wire logic restart_in,
	input wire logic [UNIT_W-1:0] delay_in,
	// start of the first conversion
	output logic conv_start_out
);
	localparam int TICK_W = $clog2(STEP_CYCLES + 1);

	typedef struct packed {
		logic pending;
		logic active;
		logic [UNIT_W-1:0] units;
		logic [TICK_W-1:0] ticks;
		logic fire;
	} timer_state_t;

	localparam timer_state_t TIMER_RESET = '{pending: 1'b1, default: '0};

	timer_state_t state_r;
	timer_state_t state_nxt;

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.fire = 1'b0;
		if (restart_in)
		begin
			state_nxt.pending = 1'b1;
			state_nxt.active = 1'b0;
		end
		else if (state_r.pending)
		begin
			// delay is taken one cycle late so a restored default is seen
			state_nxt.pending = 1'b0;
			state_nxt.active = 1'b1;
			state_nxt.units = delay_in;
			state_nxt.ticks = '0;
		end
		else if (state_r.active)
		begin
			if (state_r.units == '0)
			begin
				state_nxt.fire = 1'b1;
				state_nxt.active = 1'b0;
			end
			else if (state_r.ticks == TICK_W'(STEP_CYCLES - 1))
			begin
				state_nxt.ticks = '0;
				state_nxt.units = state_r.units - UNIT_W'(1);
			end
			else
			begin
				state_nxt.ticks = state_r.ticks + TICK_W'(1);
			end
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			state_r <= TIMER_RESET;
		else
			state_r <= state_nxt;
	end

	assign conv_start_out = state_r.fire;
endmodule

/* File: verification/pwrmon_map_sva.sv */
// concurrent checks on the register map ports
`timescale 1ns/1ps
module pwrmon_map_sva
	import pwrmon_pkg::*;
(
	// system side
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire meas_t meas_in,
	input wire cfg_t cfg_out,
	input wire logic conv_start_out,
	// serial port
	input wire logic spi_clk_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_mosi_in,
	input wire logic spi_miso_out,
	input wire logic spi_miso_oe_out
);
	logic [5:0] bit_cnt_r;
	// falling edges seen in the frame, cleared while deselected
	always_ff @(negedge spi_clk_in or posedge spi_cs_n_in)
	begin
		if (spi_cs_n_in)
			bit_cnt_r <= 6'h00;
		else if (bit_cnt_r != 6'h3F)
			bit_cnt_r <= bit_cnt_r + 6'h01;
	end
	sequence s_release;
		$rose(rst_n_in);
	endsequence
	sequence s_idle_long;
		spi_cs_n_in [*8];
	endsequence
	property p_oe_follows_cs;
		@(posedge mclk_in) disable iff (!rst_n_in) spi_miso_oe_out == !spi_cs_n_in;
	endproperty
	property p_miso_idle;
		@(posedge mclk_in) disable iff (!rst_n_in) spi_cs_n_in |-> !spi_miso_out;
	endproperty
	property p_reset_defaults;
		@(posedge mclk_in) disable iff (!rst_n_in) s_release |-> cfg_out == CFG_RESET;
	endproperty
	property p_start_after_reset;
		@(posedge mclk_in) disable iff (!rst_n_in) s_release |-> ##[1:4] conv_start_out;
	endproperty
	property p_start_pulse;
		@(posedge mclk_in) disable iff (!rst_n_in) conv_start_out |=> !conv_start_out;
	endproperty
	property p_header_quiet;
		@(negedge spi_clk_in) disable iff (spi_cs_n_in) bit_cnt_r < 6'd8 |-> !spi_miso_out;
	endproperty
	property p_miso_on_rise;
		@(posedge mclk_in) disable iff (!rst_n_in)
			!spi_cs_n_in && $changed(spi_miso_out) |-> $rose(spi_clk_in);
	endproperty
	property p_cfg_quiet;
		@(posedge mclk_in) disable iff (!rst_n_in) s_idle_long |-> $stable(cfg_out);
	endproperty
	a_oe_follows_cs: assert property (p_oe_follows_cs)
		else $error("miso enable differs from chip select");
	a_miso_idle: assert property (p_miso_idle)
		else $error("miso driven while deselected");
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("configuration not at defaults after reset");
	a_start_after_reset: assert property (p_start_after_reset)
		else $error("no start pulse after reset with zero delay");
	a_start_pulse: assert property (p_start_pulse)
		else $error("start pulse longer than one cycle");
	a_header_quiet: assert property (p_header_quiet)
		else $error("miso active during frame header");
	a_miso_on_rise: assert property (p_miso_on_rise)
		else $error("miso changed away from a rising serial clock");
	a_cfg_quiet: assert property (p_cfg_quiet)
		else $error("configuration changed while port idle");
endmodule

/* File: verification/spi_host_model.sv */
// serial host model: drives frames and collects the device reply
`timescale 1ns/1ps
module spi_host_model
(
	// serial port towards the device
	output logic sclk_out,
	output logic cs_n_out,
	output logic mosi_out,
	input wire logic miso_in
);
	initial
	begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	// clock stays low between frames; data flips once deselected so a stale level never helps
	task automatic xfer(input logic [5:0] addr, input logic rd, input logic [15:0] wdata,
		input int nbits, output logic [23:0] rdata);
		logic [31:0] tx;
		tx = {addr, 1'b0, rd, wdata, 8'h00};
		rdata = '0;
		#1.3;
		cs_n_out = 1'b0;
		#40;
		for (int i = 0; i < nbits + 8; i++)
		begin
			sclk_out = 1'b1;
			mosi_out = tx[31 - i];
			#32;
			sclk_out = 1'b0;
			if (i >= 8)
				rdata = {rdata[22:0], miso_in};
			#32;
		end
		#40;
		cs_n_out = 1'b1;
		mosi_out = ~mosi_out;
		#40;
	endtask
endmodule

/* File: verification/power_monitor_register_map_tb.sv */
// self-checking bench for the register map driven by a serial host model
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module power_monitor_register_map_tb;
	import pwrmon_pkg::*;
	localparam int STEP = 10;
	localparam logic [15:0] TB_MAKER = 16'hC3A5; // arbitrary value
	localparam logic [15:0] TB_PART = 16'h5A3C; // arbitrary value
	logic mclk_in, rst_n_in, spi_clk, spi_cs_n, spi_mosi, miso, miso_oe, conv_start;
	wire miso_pin = miso_oe ? miso : 1'bz;
	meas_t meas;
	cfg_t cfg;
	int num_errors = 0, checks_done = 0, cyc = 0, start_at = 0, t0;
	logic [23:0] d;
	logic [15:0] v;
	logic [95:0] r;
	logic [5:0] a;
	power_monitor_register_map #(.CONV_DELAY_STEP_CYCLES(STEP), .MAKER_CODE(TB_MAKER),
		.PART_CODE(TB_PART)) u_dut (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .spi_clk_in(spi_clk), .spi_cs_n_in(spi_cs_n),
		.spi_mosi_in(spi_mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
		.meas_in(meas), .cfg_out(cfg), .conv_start_out(conv_start));
	spi_host_model u_host (.sclk_out(spi_clk), .cs_n_out(spi_cs_n), .mosi_out(spi_mosi),
		.miso_in(miso_pin));
	initial
	begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end
	task automatic wrap_up();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// the start pulse is looked at mid-cycle, where it has settled
	always @(negedge mclk_in)
		if (conv_start)
			start_at = cyc;
	// a hang is cut short well past the expected run length
	always @(posedge mclk_in)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	function automatic logic [23:0] exp_meas(input logic [5:0] ad);
		case (ad)
			ADDR_SHUNT_V: return {8'h00, meas.shunt_voltage_result};
			ADDR_BUS_V: return {8'h00, meas.bus_voltage_result};
			ADDR_TEMP: return {8'h00, meas.die_temperature_result};
			ADDR_CURRENT: return {8'h00, meas.current_result};
			default: return meas.power_result;
		endcase
	endfunction
	task automatic rw(input logic [5:0] ad, input logic rd, input logic [15:0] w);
		u_host.xfer(ad, rd, w, (rd && ad == ADDR_POWER) ? 24 : 16, d);
	endtask
	initial
	begin
		rst_n_in = 1'b0;
		void'($urandom(32'h440D));
		r = {$urandom, $urandom, $urandom};
		meas = r[87:0];
		repeat (10) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (5) @(negedge mclk_in);
		rw(ADDR_GLOBAL, 1'b1, 16'h0000);
		`CHK(d, 24'h000000)
		rw(ADDR_CONVERTER, 1'b1, 16'h0000);
		`CHK(d, 24'h00FB68)
		rw(6'h03, 1'b1, 16'h0000);
		`CHK(d, 24'h000000)
		for (int k = 4; k <= 8; k++)
		begin
			rw(6'(k), 1'b1, 16'h0000);
			`CHK(d, exp_meas(6'(k)))
		end
		for (int i = 0; i < 7; i++)
		begin
			a = (i < 6) ? ADDR_THR_FIRST + 6'(i) : ADDR_DIAG;
			v = 16'($urandom);
			rw(a, 1'b0, v);
			`CHK(d[15:0], (i < 6) ? THR_RESET[i] : DIAG_RESET)
			rw(a, 1'b1, 16'h0000);
			`CHK(d[15:0], v)
			`CHK((i < 6) ? cfg.thresholds[i] : cfg.diagnostic_flag_register, v)
		end
		for (int k = 0; k < 4; k++)
		begin
			v = (k == 0) ? 16'h7FFF : (k == 1) ? 16'h0000 : 16'($urandom) & 16'h7FFF;
			rw(ADDR_GLOBAL, 1'b0, v);
			rw(ADDR_GLOBAL, 1'b1, 16'h0000);
			`CHK(d[15:0], v & 16'h3FD0)
			`CHK(cfg.shunt_range_select, v[4])
			`CHK(cfg.conversion_start_delay, v[13:6])
		end
		// bit 15 of the scale constant never sticks; the maker code ignores writes
		rw(ADDR_SHUNT_SCALE, 1'b0, 16'hFFFF);
		`CHK(d[15:0], SHUNT_SCALE_RESET)
		rw(ADDR_SHUNT_SCALE, 1'b1, 16'h0000);
		`CHK(d, 24'h007FFF)
		rw(ADDR_MAKER, 1'b0, ~TB_MAKER);
		`CHK(d[15:0], TB_MAKER)
		rw(ADDR_MAKER, 1'b1, 16'h0000);
		`CHK(d, {8'h00, TB_MAKER})
		rw(ADDR_PART, 1'b1, 16'h0000);
		`CHK(d, {8'h00, TB_PART})
		// delay of five steps, restarted by the converter setup write
		rw(ADDR_GLOBAL, 1'b0, 16'h0140);
		rw(ADDR_CONVERTER, 1'b0, 16'h1234);
		t0 = cyc;
		`CHK(cfg.converter_setup, 16'h1234)
		repeat (70) @(negedge mclk_in);
		`CHK((start_at - t0) inside {[5 * STEP - 25 : 5 * STEP + 2]}, 1'b1)
		rw(ADDR_GLOBAL, 1'b0, 16'h8000);
		repeat (5) @(negedge mclk_in);
		`CHK(cfg, CFG_RESET)
		rw(ADDR_GLOBAL, 1'b1, 16'h0000);
		`CHK(d, 24'h000000)
		rw(ADDR_CONVERTER, 1'b1, 16'h0000);
		`CHK(d, 24'h00FB68)
		rw(ADDR_SHUNT_SCALE, 1'b1, 16'h0000);
		`CHK(d, {8'h00, SHUNT_SCALE_RESET})
		wrap_up();
	end
endmodule
bind power_monitor_register_map pwrmon_map_sva u_sva (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
	.meas_in(meas_in), .cfg_out(cfg_out), .conv_start_out(conv_start_out),
	.spi_clk_in(spi_clk_in), .spi_cs_n_in(spi_cs_n_in), .spi_mosi_in(spi_mosi_in),
	.spi_miso_out(spi_miso_out), .spi_miso_oe_out(spi_miso_oe_out));
